// File: src/eve_entry.sv
`timescale 1ns/1ps
// Functional notes
// - after reset, fetch starts at fixed address 0x8000_0000 in boot flash.
// - lookup misses and supervisor call have dedicated handler spaces off the base.
// - every other exception has its own fixed entry point off the base.
// - protection violation raises instruction-side or data-side protection exception.
// - address matching no protection entry raises instruction- or data-side miss.
// - address matching several entries raises the multiple-hit exception.
// - interrupt controller gives autovector offset; core jumps to base plus offset.
// - autovector offset is 14 bits, entry points within 16384 bytes.
// - events on one instruction are serviced by fixed priority.
// - oldest instruction's events are serviced first, regardless of priority.
// - no exceptions of missing memory management, coprocessor or float units.
module eve_entry #(
	parameter int STAGES = eve_pkg::NUM_STAGES,
	parameter int ENTRIES = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [31:0] event_vector_base,
	input wire logic [STAGES-1:0] stg_valid,
	input wire logic [STAGES-1:0] stg_is_instr,
	input wire logic [STAGES*ENTRIES-1:0] stg_hit,
	input wire logic [STAGES-1:0] stg_perm_ok,
	input wire logic [STAGES*eve_pkg::NUM_EXC-1:0] stg_other_exc,
	input wire logic irq_req,
	input wire logic [eve_pkg::AUTOVEC_W-1:0] irq_autovector,
	output logic redirect,
	output logic [31:0] redirect_pc,
	output logic [3:0] exc_cause,
	output logic exc_is_irq,
	output logic [STAGES-1:0] flush_stage,
	output logic irq_ack
);
	// Stage 0 is the oldest instruction in the pipeline
	logic boot_r;
	logic redirect_r;
	logic [31:0] redirect_pc_r;
	logic [3:0] exc_cause_r;
	logic is_irq_r;
	logic [STAGES-1:0] flush_r;
	logic irq_ack_r;
	logic [STAGES*eve_pkg::NUM_EXC-1:0] stg_exc;
	logic [STAGES-1:0] stg_any;
	genvar g;
	generate
		for (g = 0; g < STAGES; g++) begin : g_stg
			logic [ENTRIES-1:0] hits;
			logic none_hit;
			logic multi_hit;
			logic ok_single;
			logic [eve_pkg::NUM_EXC-1:0] ex;
			assign hits = stg_hit[g*ENTRIES +: ENTRIES];
			assign none_hit = (hits == '0);
			assign multi_hit = ((hits & (hits - 1'b1)) != '0);
			assign ok_single = stg_valid[g] && !none_hit && !multi_hit;
			always_comb begin
				ex = stg_other_exc[g*eve_pkg::NUM_EXC +: eve_pkg::NUM_EXC];
				ex[eve_pkg::EX_IPROT] = 1'b0;
				ex[eve_pkg::EX_DPROT] = 1'b0;
				ex[eve_pkg::EX_IMISS] = 1'b0;
				ex[eve_pkg::EX_DMISS] = 1'b0;
				ex[eve_pkg::EX_MULTIHIT] = stg_valid[g] && multi_hit;
				ex[eve_pkg::EX_IMISS] = stg_valid[g] && none_hit && stg_is_instr[g];
				ex[eve_pkg::EX_DMISS] = stg_valid[g] && none_hit && !stg_is_instr[g];
				ex[eve_pkg::EX_IPROT] = ok_single && !stg_perm_ok[g] && stg_is_instr[g];
				ex[eve_pkg::EX_DPROT] = ok_single && !stg_perm_ok[g] && !stg_is_instr[g];
				if (!stg_valid[g]) begin
					ex = '0;
				end
			end
			assign stg_exc[g*eve_pkg::NUM_EXC +: eve_pkg::NUM_EXC] = ex;
			assign stg_any[g] = (ex != '0);
		end
	endgenerate
	// Only the ten ranked kinds exist; no unit-specific kinds can appear
	logic sel_found;
	logic [31:0] sel_stage;
	logic [3:0] sel_cause;
	always_comb begin
		sel_found = 1'b0;
		sel_stage = '0;
		sel_cause = '0;
		for (int s = STAGES - 1; s >= 0; s--) begin
			if (stg_any[s]) begin
				sel_found = 1'b1;
				sel_stage = 32'(s);
			end
		end
		for (int k = eve_pkg::NUM_EXC - 1; k >= 0; k--) begin
			if (stg_exc[sel_stage*eve_pkg::NUM_EXC + k]) begin
				sel_cause = 4'(k);
			end
		end
	end
	logic [31:0] exc_target;
	logic [31:0] irq_target;
	logic [STAGES-1:0] flush_mask;
	assign exc_target = event_vector_base + eve_pkg::EXC_OFS[sel_cause];
	assign irq_target = event_vector_base + {18'h0, irq_autovector};
	assign flush_mask = ~STAGES'((32'h1 << sel_stage) - 32'h1);
	// A request still high in the cycle of its own acknowledge is not taken twice
	logic irq_take;
	assign irq_take = !boot_r && !sel_found && irq_req && !irq_ack_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			boot_r <= 1'b1;
			redirect_r <= 1'b0;
			redirect_pc_r <= eve_pkg::RESET_ADDR;
			exc_cause_r <= '0;
			is_irq_r <= 1'b0;
			flush_r <= '0;
			irq_ack_r <= 1'b0;
		end else begin
			boot_r <= 1'b0;
			redirect_r <= boot_r || sel_found || irq_take;
			irq_ack_r <= irq_take;
			is_irq_r <= irq_take;
			exc_cause_r <= sel_cause;
			if (boot_r) begin
				redirect_pc_r <= eve_pkg::RESET_ADDR;
				flush_r <= '1;
			end else if (sel_found) begin
				redirect_pc_r <= exc_target;
				flush_r <= flush_mask[STAGES-1:0];
			end else begin
				redirect_pc_r <= irq_target;
				flush_r <= irq_take ? '1 : '0;
			end
		end
	end
	assign redirect = redirect_r;
	assign redirect_pc = redirect_pc_r;
	assign exc_cause = exc_cause_r;
	assign exc_is_irq = is_irq_r;
	assign flush_stage = flush_r;
	assign irq_ack = irq_ack_r;
endmodule

// File: src/eve_pkg.sv
package eve_pkg;
	localparam logic [31:0] RESET_ADDR = 32'h8000_0000;
	localparam int AUTOVEC_W = 14;
	localparam int NUM_STAGES = 3;
	localparam int NUM_EXC = 10;
	// Exception kinds, indexed by priority rank (0 is highest)
	localparam int EX_UNRECOV = 0;
	localparam int EX_BUS_INSTR = 1;
	localparam int EX_IPROT = 2;
	localparam int EX_IMISS = 3;
	localparam int EX_MULTIHIT = 4;
	localparam int EX_ILLEGAL = 5;
	localparam int EX_PRIV = 6;
	localparam int EX_SCALL = 7;
	localparam int EX_DPROT = 8;
	localparam int EX_DMISS = 9;
	// Handler offsets from the event vector base, one per rank
	localparam logic [31:0] EXC_OFS [NUM_EXC] = '{
		32'h0000_0000, 32'h0000_0008, 32'h0000_0018, 32'h0000_0050, 32'h0000_0014,
		32'h0000_0020, 32'h0000_0024, 32'h0000_0100, 32'h0000_0028, 32'h0000_0060
	};
endpackage

// File: tb/eve_entry_properties.sv
`timescale 1ns/1ps
module eve_entry_properties #(
	parameter int STAGES = eve_pkg::NUM_STAGES,
	parameter int ENTRIES = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic irq_req,
	input wire logic irq_ack,
	input wire logic redirect,
	input wire logic exc_is_irq,
	input wire logic [31:0] redirect_pc,
	input wire logic [STAGES-1:0] stg_valid,
	input wire logic [STAGES-1:0] stg_is_instr,
	input wire logic [STAGES-1:0] stg_perm_ok,
	input wire logic [STAGES*ENTRIES-1:0] stg_hit,
	input wire logic [STAGES*eve_pkg::NUM_EXC-1:0] stg_other_exc,
	input wire logic [3:0] exc_cause,
	input wire logic [STAGES-1:0] flush_stage
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic [ENTRIES-1:0] h=stg_hit[ENTRIES-1:0];
	sequence s1; stg_valid==1 && stg_other_exc[9:0]==0 && !$fell(rst); endsequence
	sequence s_irq; irq_req && !irq_ack && stg_valid==0 && !$fell(rst); endsequence
	AST_RST: assert property ($fell(rst) |=> redirect && redirect_pc==eve_pkg::RESET_ADDR) else $error("boot");
	AST_MISS: assert property (s1 ##0 h==0 |=> exc_cause==($past(stg_is_instr[0])?3:9)) else $error("miss");
	AST_MULTI: assert property (s1 ##0 $countones(h)>1 |=> exc_cause==4) else $error("multi");
	AST_PROT: assert property (s1 ##0 $onehot(h) && !stg_perm_ok[0]
		|=> exc_cause==($past(stg_is_instr[0])?2:8)) else $error("prot");
	AST_OLD: assert property (stg_valid[0] && $onehot(h) && stg_perm_ok[0] && stg_other_exc[9:0]==10'h020
		|=> exc_cause==5) else $error("age");
	AST_IRQ: assert property (s_irq |=> irq_ack && exc_is_irq && flush_stage=='1) else $error("irq");
	AST_ONCE: assert property (irq_ack |=> !irq_ack) else $error("second take");
	AST_FLUSH: assert property (s1 ##0 h==0 |=> redirect && !exc_is_irq && flush_stage=='1) else $error("flush");
	AST_REF: assert property (stg_valid[0] && h==0 |=> !irq_ack) else $error("refuse");
	AST_IDLE: assert property (stg_valid==0 && !irq_req && !$fell(rst) |=> !redirect) else $error("idle");
endmodule
bind eve_entry eve_entry_properties #(.STAGES(STAGES), .ENTRIES(ENTRIES)) u_props (.*);

// File: tb/eve_irq_ctl.sv
`timescale 1ns/1ps
module eve_irq_ctl (
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire logic irq_ack,
	input wire logic [13:0] ofs,
	output logic irq_req,
	output logic [13:0] irq_autovector
);
	always_ff @(posedge clk) begin
		irq_req <= !rst && !irq_ack && (irq_req || go);
		irq_autovector <= rst ? 14'h0 : go ? ofs : irq_req ? irq_autovector : ~irq_autovector;
	end
endmodule

// File: tb/test_event_vector_entry.sv
`timescale 1ns/1ps
module test_event_vector_entry;
	logic clk=0, rst=1, go=0, b, irq_req, irq_ack, redirect, exc_is_irq;
	logic [31:0] event_vector_base='0, redirect_pc;
	logic [2:0] stg_valid='0, stg_is_instr='0, stg_perm_ok='0, flush_stage;
	logic [23:0] stg_hit='0;
	logic [29:0] stg_other_exc='0;
	logic [13:0] irq_autovector, ofs='0;
	logic [3:0] exc_cause;
	int fails=0, compares=0, cyc=0;
	eve_entry DUT (.*);
	eve_irq_ctl PIC (.*);
	initial forever #10 clk=~clk;
	always @(posedge clk) if (++cyc>3000) begin fails++; conclude(); end
	task conclude();
		$display("fails %0d compares %0d", fails, compares);
		if (fails==0 && compares>0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input logic [40:0] g, e);
		compares++;
		if (g!==e) begin fails++; $display("MISMATCH %0t %h %h", $time, g, e); end
	endtask
	function logic [40:0] vec(input int r, input logic [2:0] f);
		return {2'b10, 4'(r), f, event_vector_base+eve_pkg::EXC_OFS[r]};
	endfunction
	task run(input logic [2:0] v, i, p, input logic [23:0] h, input logic [29:0] o, input int r,
		input logic [2:0] f = 3'h7);
		@(posedge clk) {stg_valid, stg_is_instr, stg_perm_ok, stg_hit, stg_other_exc} <= {v, i, p, h, o};
		event_vector_base <= $urandom & 32'hFFFF_FF00;
		@(posedge clk) #1 chk({redirect, exc_is_irq, exc_cause, flush_stage, redirect_pc}, vec(r, f));
		$display("done %0d", r);
	endtask
	task boot_chk();
		@(posedge clk) #1 chk(41'({redirect, flush_stage, redirect_pc}), 41'({4'hF, eve_pkg::RESET_ADDR}));
		$display("boot done");
	endtask
	task irq(input logic [13:0] x, input logic m);
		logic [40:0] exp_v;
		exp_v = 41'({6'h3F, event_vector_base+{18'h0, x}});
		@(posedge clk) {go, ofs, stg_valid, stg_hit} <= {1'b1, x, 2'h0, m, 24'h0};
		@(posedge clk) go <= 1'b0;
		@(posedge clk) stg_valid <= 3'h0;
		#1 if (m) chk(41'(irq_ack), 41'h0);
		repeat (6) if (irq_ack!==1'b1) #20;
		chk(41'({redirect, irq_ack, exc_is_irq, flush_stage, redirect_pc}), exp_v);
		$display("irq done");
	endtask
	initial begin
		void'($urandom(43));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		boot_chk();
		repeat (4) begin
			b = 1'($urandom);
			run(3'h1, {2'h0, b}, 3'h0, 24'h0, 30'h0, b ? 3 : 9);
			run(3'h1, {2'h0, b}, 3'h0, 24'h1, 30'h0, b ? 2 : 8);
		end
		run(3'h1, 3'h1, 3'h1, 24'h0C0, 30'h0, 4);
		for (int k=0; k<8; k++) if (k<2 || k>4) run(3'h1, 3'h1, 3'h1, 24'h1, 30'h1<<k, k);
		run(3'h1, 3'h1, 3'h1, 24'h1, 30'h0A0, 5);
		run(3'h3, 3'h3, 3'h3, 24'h101, 30'h420, 5);
		run(3'h3, 3'h3, 3'h3, 24'h101, 30'h8000, 5, 3'h6);
		@(posedge clk) rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		boot_chk();
		irq(14'h3FFF, 1'b1);
		irq(14'($urandom), 1'b0);
		conclude();
	end
endmodule
